// *** kms_consts.svh ***
/*
 * constants for the key matrix scanner: matrix size, debounce defaults, reset values.
 * assumes it is included by bare name from the scanner files.
 */
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH

// matrix geometry
`define KMS_ROWS 8
`define KMS_COLS 8
`define KMS_KEYS 64

// debounce count field width and its reset value
`define KMS_DEB_W 8
`define KMS_DEB_RESET 8'h04

// row drive values: every row high while idle, no row, first scan row
`define KMS_ROWS_ALL 8'hFF
`define KMS_ROWS_NONE 8'h00
`define KMS_ROW_FIRST 8'h01

`endif

// *** kms_pkg.sv ***
/*
 * types shared by the key matrix scanner files.
 * assumes kms_consts.svh is on the include path.
 */
`include "kms_consts.svh"

package kms_pkg;
	// whole keypad image, bit r*8+c is row r column c
	typedef logic [`KMS_KEYS-1:0] kms_matrix_t;

	// report towards the processor side
	typedef struct packed {
		logic irq; // one-cycle new-state pulse
		logic wake; // one-cycle wake-up pulse
	} kms_event_s;

	// scanner sequencing
	typedef enum logic [1:0] {
		KMS_IDLE,
		KMS_SCAN,
		KMS_SETTLE
	} kms_state_e;
endpackage : kms_pkg

// *** kms_debounce.sv ***
/*
 * debounce stage: accepts a scanned matrix image only once it has repeated
 * unchanged for a programmable number of complete scans.
 * assumes one i_frame_vld pulse per finished scan, same clock as the scanner.
 */
`timescale 1ns/100ps
`include "kms_consts.svh"

module kms_debounce #(
	parameter int KEYS = `KMS_KEYS,
	parameter int DEB_W = `KMS_DEB_W
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_frame_vld,
	input wire logic [KEYS-1:0] i_frame,
	input wire logic [DEB_W-1:0] i_deb_count,
	output logic o_accept,
	output logic [KEYS-1:0] o_frame
);
	////////////////////////////////////////////////////////////////////////
	logic [KEYS-1:0] last_reg; // previous scan image
	logic [DEB_W-1:0] same_reg; // scans seen identical in a row
	logic [DEB_W-1:0] same_next;
	logic accept_next;
	wire same_w = (i_frame == last_reg);
	// a zero count is treated as one, so an image is accepted after one identical repeat
	wire [DEB_W-1:0] need_w = (i_deb_count == '0) ? DEB_W'(1) : i_deb_count;

	// count repeats, fire once when the run reaches the programmed length
	assign same_next = same_w ? ((same_reg == need_w) ? same_reg : same_reg + DEB_W'(1)) : '0; // see R10
	assign accept_next = i_frame_vld && same_w && (same_reg + DEB_W'(1) == need_w); // see R10

	////////////////////////////////////////////////////////////////////////
	// image and repeat count registers update only per finished scan; o_accept every cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			last_reg <= '0;
			same_reg <= '0;
			o_accept <= 1'b0;
			o_frame <= '0;
		end else begin
			o_accept <= accept_next;
			if (i_frame_vld) begin
				last_reg <= i_frame;
				same_reg <= same_next;
			end
			if (accept_next) begin
				o_frame <= i_frame;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// an accepted image equals the scan that triggered it
	accept_img_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R10
		accept_next |=> (o_accept && o_frame == $past(i_frame)))
		else $error("debounce accept lost its frame");
	// a changed scan never yields an accept
	change_block_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R10
		(i_frame_vld && !same_w) |=> !o_accept)
		else $error("accept after changed scan");
endmodule : kms_debounce

// *** kms_scanner.sv ***
/*
 * key matrix scanner for an 8 by 8 keypad.
 * idles with all rows high, scans row by row on activity, debounces,
 * stores the keypad image and pulses an interrupt and a wake-up.
 * assumes i_core_clk is the slow timebase clock and column inputs are
 * synchronous to it with pull-downs on the column lines.
 */
// Functional notes
// R1: up to 64 keys, 8 rows by 8 columns
// R2: idle drives all rows high, watches columns
// R3: scan drives one row high, samples columns
// R4: store and interrupt only after debounce
// R5: keep scanning after report for changes
// R6: new state stored then fresh interrupt
// R7: every key combination reported individually
// R8: key press produces Stop mode wake-up
// R9: clocked from slow timebase clock
// R10: debounce needs programmable count identical scans
`timescale 1ns/100ps
`include "kms_consts.svh"

module kms_scanner #(
	parameter int ROWS = `KMS_ROWS,
	parameter int COLS = `KMS_COLS,
	parameter int DEB_W = `KMS_DEB_W
) (
	input wire logic i_core_clk, // slow timebase clock
	input wire logic i_srst,
	input wire logic [COLS-1:0] i_key_col, // column inputs
	input wire logic [DEB_W-1:0] i_deb_count, // scans required stable
	output logic [ROWS-1:0] o_key_row, // row drive
	output kms_pkg::kms_matrix_t o_matrix, // stored keypad state
	output kms_pkg::kms_event_s o_event, // irq and wake pulses
	output logic o_scanning // high while not idle
);
	////////////////////////////////////////////////////////////////////////
	// state
	// width of the row index; a named constant keeps the size casts below legal
	localparam int IDX_W = $clog2(ROWS);
	kms_pkg::kms_state_e state_reg, state_next;
	logic [ROWS-1:0] row_reg, row_next; // one-hot row under test
	logic [$clog2(ROWS)-1:0] idx_reg, idx_next; // row index
	kms_pkg::kms_matrix_t frame_reg, frame_next; // image being built
	logic frame_vld_reg, frame_vld_next; // full scan finished
	logic deb_accept; // debounced image ready
	kms_pkg::kms_matrix_t deb_frame;

	// decoded conditions
	wire any_col_w = |i_key_col; // see R2
	wire last_row_w = (idx_reg == IDX_W'(ROWS - 1));
	wire all_open_w = (o_matrix == '0) && (deb_frame == '0);

	////////////////////////////////////////////////////////////////////////
	// sequencing: one cycle per row drive, sample on the next (settle)
	always_comb begin
		state_next = state_reg;
		row_next = row_reg;
		idx_next = idx_reg;
		frame_next = frame_reg;
		frame_vld_next = 1'b0;
		unique case (state_reg)
			kms_pkg::KMS_IDLE: begin
				row_next = `KMS_ROWS_ALL; // see R2
				if (any_col_w) begin
					state_next = kms_pkg::KMS_SCAN; // see R3
					row_next = `KMS_ROW_FIRST;
					idx_next = '0;
				end
			end
			kms_pkg::KMS_SCAN: begin
				// row already driven; let it settle one cycle before sampling
				state_next = kms_pkg::KMS_SETTLE;
			end
			kms_pkg::KMS_SETTLE: begin
				// every column of this row lands in its own bit: see R7
				frame_next[idx_reg*COLS +: COLS] = i_key_col; // see R3
				if (last_row_w) begin
					frame_vld_next = 1'b1;
					idx_next = '0;
					row_next = `KMS_ROW_FIRST;
					// back to idle only when nothing is held and reported; see R5
					state_next = (frame_next == '0 && all_open_w) ? kms_pkg::KMS_IDLE : kms_pkg::KMS_SCAN;
					if (state_next == kms_pkg::KMS_IDLE) begin
						row_next = `KMS_ROWS_ALL;
					end
				end else begin
					idx_next = idx_reg + 1'b1;
					row_next = {row_reg[ROWS-2:0], 1'b0}; // see R3
					state_next = kms_pkg::KMS_SCAN;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer registers; runs on the slow clock so stop mode keeps it alive, see R9
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_reg <= kms_pkg::KMS_IDLE;
			row_reg <= `KMS_ROWS_ALL;
			idx_reg <= '0;
			frame_reg <= '0;
			frame_vld_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			row_reg <= row_next;
			idx_reg <= idx_next;
			frame_reg <= frame_next;
			frame_vld_reg <= frame_vld_next;
		end
	end

	assign o_key_row = row_reg; // see R1

	////////////////////////////////////////////////////////////////////////
	// debounce of complete scan images
	kms_debounce #(
		.KEYS(ROWS * COLS),
		.DEB_W(DEB_W)
	) u_debounce (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_frame_vld(frame_vld_reg),
		.i_frame(frame_reg),
		.i_deb_count(i_deb_count),
		.o_accept(deb_accept),
		.o_frame(deb_frame)
	);

	// a debounced image differing from the stored one is a new state
	// equal images give no interrupt, so a held key reports once; a bounce
	// shorter than the debounce run never reaches the processor side
	wire new_state_w = deb_accept && (deb_frame != o_matrix); // see R6
	wire press_w = new_state_w && ((deb_frame & ~o_matrix) != '0); // see R8

	////////////////////////////////////////////////////////////////////////
	// store state and pulse the interrupt and wake-up on the same clock edge
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_matrix <= '0;
			o_event <= '0;
			o_scanning <= 1'b0;
		end else begin
			o_event.irq <= new_state_w; // see R4
			o_event.wake <= press_w; // see R8
			o_scanning <= (state_next != kms_pkg::KMS_IDLE);
			if (new_state_w) begin
				o_matrix <= deb_frame; // see R6
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// idle keeps every row high
	idle_rows_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R2
		(state_reg == kms_pkg::KMS_IDLE) |-> (o_key_row == `KMS_ROWS_ALL))
		else $error("rows not all high in idle");
	// scanning drives exactly one row
	one_row_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R3
		(state_reg != kms_pkg::KMS_IDLE) |-> $onehot(o_key_row))
		else $error("scan row not one-hot");
	// column activity in idle starts a scan next cycle
	idle_wake_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R2
		(state_reg == kms_pkg::KMS_IDLE && any_col_w) |=> (state_reg == kms_pkg::KMS_SCAN && o_key_row == `KMS_ROW_FIRST))
		else $error("column change did not start scan");
	// interrupt only follows a debounce accept
	irq_cause_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R4
		o_event.irq |-> $past(deb_accept))
		else $error("interrupt without debounce");
	// interrupt comes with the matrix updated to the accepted image
	irq_store_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R6
		o_event.irq |-> (o_matrix == $past(deb_frame) && o_matrix != $past(o_matrix)))
		else $error("matrix not stored with interrupt");
	// after a report with keys held the scanner keeps scanning
	keep_scan_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R5
		(o_event.irq && o_matrix != '0) |-> (state_reg != kms_pkg::KMS_IDLE))
		else $error("scan stopped while keys held");
	// a scanned row lands in its own slice
	row_slice_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R7
		(state_reg == kms_pkg::KMS_SETTLE) |=> (frame_reg[$past(idx_reg)*COLS +: COLS] == $past(i_key_col)))
		else $error("row image misplaced");
	// wake-up only with an interrupt for a newly pressed key
	wake_irq_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R8
		o_event.wake |-> (o_event.irq && ((o_matrix & ~$past(o_matrix)) != '0)))
		else $error("wake without new press");
	// settle always follows a row drive
	settle_seq_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R3
		(state_reg == kms_pkg::KMS_SCAN) |=> (state_reg == kms_pkg::KMS_SETTLE) ##1 (state_reg != kms_pkg::KMS_SETTLE))
		else $error("scan timing broken");

	////////////////////////////////////////////////////////////////////////
	// sequencer and report bookkeeping
	// the scanning flag mirrors the sequencer state
	scan_flag_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R2
		o_scanning == (state_reg != kms_pkg::KMS_IDLE))
		else $error("scanning flag out of step");
	// quiet columns keep the sequencer idle
	idle_stay_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R2
		(state_reg == kms_pkg::KMS_IDLE && !any_col_w) |=> (state_reg == kms_pkg::KMS_IDLE))
		else $error("idle left without column activity");
	// the driven row holds through its settle cycle
	row_hold_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R3
		(state_reg == kms_pkg::KMS_SCAN) |=> $stable(o_key_row))
		else $error("row changed before sampling");
	// a finished scan always ends on the last row
	frame_done_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R7
		frame_vld_reg |-> ($past(state_reg) == kms_pkg::KMS_SETTLE && $past(idx_reg) == IDX_W'(ROWS - 1)))
		else $error("scan image closed early");
	// idle is only re-entered with an empty stored image
	idle_entry_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R5
		(state_reg == kms_pkg::KMS_IDLE && $past(state_reg) != kms_pkg::KMS_IDLE) |-> (o_matrix == '0))
		else $error("idle entered with keys reported");
	// the interrupt is a single-cycle pulse
	irq_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R6
		o_event.irq |=> !o_event.irq)
		else $error("interrupt longer than one cycle");
	// the stored image changes only together with an interrupt
	matrix_hold_a: assert property (@(posedge i_core_clk) disable iff (i_srst) // see R6
		!o_event.irq |-> $stable(o_matrix))
		else $error("matrix changed without interrupt");
endmodule : kms_scanner

// *** kms_keypad_model.sv ***
/*
 * passive key switch matrix: a closed key joins its row to its column.
 * assumes pull-downs on every column, so an open column reads low.
 */
`timescale 1ns/100ps

module kms_keypad_model (
	input wire logic [7:0] i_row, // row drive from the scanner
	input wire logic [63:0] i_pressed, // bit r*8+c closed
	output logic [7:0] o_col // column lines back to the scanner
);
	//////////////////////////////////////////////////////////////////////////
	// a column is high only through a closed key on a row driven high;
	// the pull-down settles every other column to 0
	always_comb begin
		o_col = 8'h00;
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				if (i_row[r] && i_pressed[r*8+c]) begin
					o_col[c] = 1'b1;
				end
			end
		end
	end
endmodule : kms_keypad_model

// *** key_matrix_scanner_test.sv ***
/*
 * self-checking bench for the key matrix scanner with a switch matrix model.
 * assumes the scanner reports through one-cycle irq and wake pulses.
 */
`timescale 1ns/100ps

module key_matrix_scanner_test;
	logic i_core_clk = 1'b0; // slow timebase clock stand-in
	logic i_srst = 1'b1; // held for the first 4 cycles
	logic [7:0] i_deb_count = 8'h03; // scans required stable
	logic [63:0] pressed = 64'h0; // keys held by the bench
	wire logic [7:0] key_col;
	wire logic [7:0] key_row;
	kms_pkg::kms_matrix_t matrix;
	kms_pkg::kms_event_s evt;
	logic scanning;
	int mismatches = 0;
	int samples_checked = 0;
	int n;

	initial forever #5 i_core_clk = ~i_core_clk;

	kms_scanner dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_key_col(key_col),
		.i_deb_count(i_deb_count), .o_key_row(key_row), .o_matrix(matrix), .o_event(evt),
		.o_scanning(scanning));
	kms_keypad_model keypad_u (.i_row(key_row), .i_pressed(pressed), .o_col(key_col));

	//////////////////////////////////////////////////////////////////////////
	task conclude;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// waits for the next report; rows off idle must stay one-hot meanwhile
	task wait_report(output int cycles);
		cycles = 0;
		// always step at least one cycle so a pulse still standing from the last report is not taken again
		do begin
			@(negedge i_core_clk);
			cycles++;
			if (key_row !== 8'hFF) check("row_onehot", $onehot(key_row), 64'h1);
			if (cycles > 2000) begin
				mismatches++;
				conclude();
			end
		end while (evt.irq !== 1'b1);
	endtask : wait_report

	//////////////////////////////////////////////////////////////////////////
	// nothing pressed: rows all high, sequencer stays idle
	task idle_quiet;
		repeat (40) @(negedge i_core_clk);
		check("idle_rows", key_row, 64'hFF);
		check("idle_scan", scanning, 64'h0);
		check("idle_matrix", matrix, 64'h0);
	endtask : idle_quiet

	// one key: first scan plus three identical repeats, then the report pipeline
	task first_press;
		pressed = 64'h1;
		wait_report(n);
		check("deb_wait", n > 64 && n <= 68, 64'h1);
		check("first_img", matrix, 64'h1);
		check("first_wake", evt.wake, 64'h1);
	endtask : first_press

	// extra keys at row 1 column 1 and the far corner while the first is held
	task extra_press;
		pressed = 64'h8000_0000_0000_0201;
		wait_report(n);
		check("extra_img", matrix, 64'h8000_0000_0000_0201);
		check("extra_wake", evt.wake, 64'h1);
		// an unchanged image must not report again
		n = 0;
		repeat (100) begin
			@(negedge i_core_clk);
			if (evt.irq === 1'b1) n++;
		end
		check("no_repeat_irq", n, 64'h0);
	endtask : extra_press

	// release: a zero image is reported, then the sequencer idles
	task release_all;
		pressed = 64'h0;
		wait_report(n);
		check("rel_img", matrix, 64'h0);
		check("rel_wake", evt.wake, 64'h0);
		n = 0;
		while (scanning !== 1'b0 && n < 100) begin
			@(negedge i_core_clk);
			n++;
		end
		@(negedge i_core_clk);
		check("back_idle", scanning, 64'h0);
		check("back_rows", key_row, 64'hFF);
	endtask : release_all

	// zero debounce count acts as one repeat: report after two identical scans
	task fast_debounce;
		i_deb_count = 8'h00;
		pressed = 64'h0000_0000_0010_0000;
		wait_report(n);
		check("fast_wait", n > 32 && n <= 36, 64'h1);
		check("fast_img", matrix, 64'h0000_0000_0010_0000);
		check("fast_wake", evt.wake, 64'h1);
	endtask : fast_debounce

	// reset while a key is held clears the report, then the key is found again
	task reset_mid;
		i_srst = 1'b1;
		repeat (3) @(negedge i_core_clk);
		check("rst_matrix", matrix, 64'h0);
		check("rst_irq", evt.irq, 64'h0);
		check("rst_rows", key_row, 64'hFF);
		check("rst_scan", scanning, 64'h0);
		i_srst = 1'b0;
		wait_report(n);
		check("rst_wait", n > 32 && n <= 36, 64'h1);
		check("rst_img", matrix, 64'h0000_0000_0010_0000);
		check("rst_wake", evt.wake, 64'h1);
	endtask : reset_mid

	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge i_core_clk);
		i_srst = 1'b0;
		idle_quiet();
		first_press();
		extra_press();
		release_all();
		fast_debounce();
		reset_mid();
		release_all();
		conclude();
	end
endmodule : key_matrix_scanner_test
